/* File: inc/gfc_defs.svh */
`ifndef GFC_DEFS_SVH
`define GFC_DEFS_SVH

// Clock of the block
`define GFC_CLK_NS        5
`define GFC_CLK_HZ        200000000

// Reference clock and its divider
`define GFC_REF_HZ        100000
`define GFC_REF_DIV       (`GFC_CLK_HZ / `GFC_REF_HZ)

// Timebase and counter chain
`define GFC_TB_STAGES     3
`define GFC_DIGITS        4
`define GFC_DEC_MAX       4'h9
`define GFC_BCD_W         4
`define GFC_NUMERALS      10

// Reset pulse width, least time
`define GFC_RST_NS        10000
`define GFC_RST_CYC       ((`GFC_RST_NS + `GFC_CLK_NS - 1) / `GFC_CLK_NS)

`endif

/* File: inc/gfc_pkg.sv */
package gfc_pkg;

  typedef enum logic [1:0] {
    GFC_PH_RESET = 2'b00,
    GFC_PH_COUNT = 2'b01,
    GFC_PH_SHOW  = 2'b10
  } gfc_phase_t;

  typedef logic [3:0] gfc_bcd_t;
  typedef logic [9:0] gfc_numeral_t;

endpackage : gfc_pkg

/* File: inc/gfc_dec_if.sv */
interface gfc_dec_if;
  logic              en;
  logic              clr;
  logic              carry;
  gfc_pkg::gfc_bcd_t bcd;

  modport cnt (
    input  en,
    input  clr,
    output carry,
    output bcd
  );

  modport user (
    output en,
    output clr,
    input  carry,
    input  bcd
  );
endinterface : gfc_dec_if

/* File: verilog/gfc_decade.sv */
`include "gfc_defs.svh"

module gfc_decade (
  input wire logic clk,
  input wire logic nrst,
  gfc_dec_if.cnt   d
);

  gfc_pkg::gfc_bcd_t cnt_q;

  // Modulo ten count, cleared on demand, held when idle
  always_ff @(posedge clk) begin
    if (!nrst || d.clr) begin
      cnt_q <= 4'h0;
    end else if (d.en) begin
      if (cnt_q == `GFC_DEC_MAX) begin
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  assign d.bcd   = cnt_q;
  assign d.carry = d.en && !d.clr && (cnt_q == `GFC_DEC_MAX);

endmodule : gfc_decade

/* File: verilog/gfc_counter.sv */
`include "gfc_defs.svh"

module gfc_counter #(
  parameter int DIGITS  = `GFC_DIGITS,
  parameter int REF_DIV = `GFC_REF_DIV,
  parameter int RST_CYC = `GFC_RST_CYC
) (
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire logic                             rf_in,
  output      logic                             ref_tick,
  output      logic                             read_cmd,
  output      logic                             count_gate,
  output      logic                             trigger,
  output      logic                             reset_pulse,
  output      logic                             display_on,
  output      logic [DIGITS*`GFC_NUMERALS-1:0]  digit_drive,
  output      logic [DIGITS*`GFC_BCD_W-1:0]     count_bcd,
  output      logic                             overrange,
  output      gfc_pkg::gfc_phase_t              phase
);

  localparam int REF_W = $clog2(REF_DIV);
  localparam int RST_W = $clog2(RST_CYC + 1);

  // BCD to one-of-ten numeral drive
  function automatic gfc_pkg::gfc_numeral_t bcd_to_numeral(
    input gfc_pkg::gfc_bcd_t b
  );
    gfc_pkg::gfc_numeral_t n;
    n = 10'h000;
    if (b <= `GFC_DEC_MAX) begin
      n[b] = 1'b1;
    end
    return n;
  endfunction : bcd_to_numeral

  // Nine is the only legal code with weights 1 and 8 both set
  function automatic logic bcd_is_nine(
    input gfc_pkg::gfc_bcd_t b
  );
    return b[0] && b[3];
  endfunction : bcd_is_nine

  // Reference tick divider
  logic [REF_W-1:0] ref_cnt_q;
  logic             ref_tick_q;

  // Wraps every REF_DIV clocks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_cnt_q  <= '0;
      ref_tick_q <= 1'b0;
    end else if (ref_cnt_q == REF_W'(REF_DIV - 1)) begin
      ref_cnt_q  <= '0;
      ref_tick_q <= 1'b1;
    end else begin
      ref_cnt_q  <= ref_cnt_q + REF_W'(1);
      ref_tick_q <= 1'b0;
    end
  end

  assign ref_tick = ref_tick_q;

  // Timebase decades
  gfc_dec_if tb_if [`GFC_TB_STAGES] ();

  // Timebase decades are never cleared, so the tick chain runs free
  genvar t;
  generate
    for (t = 0; t < `GFC_TB_STAGES; t++) begin : g_tb
      if (t == 0) begin : g_first
        assign tb_if[t].en = ref_tick_q;
      end else begin : g_next
        assign tb_if[t].en = tb_if[t-1].carry;
      end
      assign tb_if[t].clr = 1'b0;
      gfc_decade u_tb (
        .clk  (clk),
        .nrst (nrst),
        .d    (tb_if[t])
      );
    end
  endgenerate

  // Divide by two stage
  logic toggle_q;

  // Flips on each carry out of the last timebase stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      toggle_q <= 1'b0;
    end else if (tb_if[`GFC_TB_STAGES-1].carry) begin
      toggle_q <= !toggle_q;
    end
  end

  // Read command is the inverse of the toggle
  logic read_w;
  assign read_w   = !toggle_q;
  assign read_cmd = read_w;

  // Reset condition: stage two at 9, stage three at 9, toggle high
  logic stage2_nine;
  logic stage3_nine;
  logic rst_cond;
  logic rst_cond_q;
  logic trig_q;

  assign stage2_nine = bcd_is_nine(tb_if[1].bcd);
  assign stage3_nine = bcd_is_nine(tb_if[2].bcd);
  assign rst_cond    = stage2_nine && stage3_nine && toggle_q;

  // Trigger marks only the first cycle of the reset condition
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_cond_q <= 1'b0;
      trig_q     <= 1'b0;
    end else begin
      rst_cond_q <= rst_cond;
      trig_q     <= rst_cond && !rst_cond_q;
    end
  end

  assign trigger = trig_q;

  // Fixed width reset pulse, launched by the trigger
  logic [RST_W-1:0] rst_cnt_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_cnt_q <= '0;
    end else if (trig_q) begin
      rst_cnt_q <= RST_W'(RST_CYC);
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - RST_W'(1);
    end
  end

  logic rst_w;
  assign rst_w       = (rst_cnt_q != '0);
  assign reset_pulse = rst_w;

  // Input count gate
  logic gate_d;
  logic gate_q;
  logic rf_inc;

  always_comb begin
    if (read_w) begin
      gate_d = !rf_in;
    end else begin
      gate_d = 1'b1;
    end
  end

  // Gate register, also the edge memory for counting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gate_q <= 1'b1;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign count_gate = gate_q;
  // Rising gate edges count only while reading, so gate closure adds none
  assign rf_inc = read_w && gate_d && !gate_q && !rst_w;

  // RF counter decades
  gfc_dec_if rf_if [DIGITS] ();

  // Whole chain cleared by the reset pulse
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_rf
      if (g == 0) begin : g_first
        assign rf_if[g].en = rf_inc;
      end else begin : g_next
        assign rf_if[g].en = rf_if[g-1].carry;
      end
      assign rf_if[g].clr = rst_w;
      gfc_decade u_rf (
        .clk  (clk),
        .nrst (nrst),
        .d    (rf_if[g])
      );
    end
  endgenerate

  // Overrange flag, cleared by the reset pulse
  logic ovr_q;

  always_ff @(posedge clk) begin
    if (!nrst || rst_w) begin
      ovr_q <= 1'b0;
    end else if (rf_if[DIGITS-1].carry) begin
      ovr_q <= 1'b1;
    end
  end

  assign overrange = ovr_q;

  // Stored BCD and decoded digit drives
  logic [DIGITS*`GFC_BCD_W-1:0]    bcd_q;
  logic [DIGITS*`GFC_NUMERALS-1:0] drive_q;
  logic                            disp_q;

  generate
    for (g = 0; g < DIGITS; g++) begin : g_out
      gfc_pkg::gfc_bcd_t     dig_q;
      gfc_pkg::gfc_numeral_t drv_q;

      always_ff @(posedge clk) begin
        if (!nrst) begin
          dig_q <= 4'h0;
        end else begin
          dig_q <= rf_if[g].bcd;
        end
      end

      // Drives cleared while counting so no numeral shows
      always_ff @(posedge clk) begin
        if (!nrst || read_w) begin
          drv_q <= 10'h000;
        end else begin
          drv_q <= bcd_to_numeral(rf_if[g].bcd);
        end
      end

      assign bcd_q[g*`GFC_BCD_W +: `GFC_BCD_W]         = dig_q;
      assign drive_q[g*`GFC_NUMERALS +: `GFC_NUMERALS] = drv_q;
    end
  endgenerate

  // Display lit one cycle after read falls, in step with the drives
  always_ff @(posedge clk) begin
    if (!nrst) begin
      disp_q <= 1'b0;
    end else begin
      disp_q <= !read_w;
    end
  end

  assign count_bcd   = bcd_q;
  assign digit_drive = drive_q;
  assign display_on  = disp_q;

  // Phase of the repeating sequence
  gfc_pkg::gfc_phase_t phase_q;

  // Reported sequence only; nothing else depends on it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_q <= gfc_pkg::GFC_PH_SHOW;
    end else begin
      unique case (phase_q)
        gfc_pkg::GFC_PH_RESET: begin
          if (read_w) begin
            phase_q <= gfc_pkg::GFC_PH_COUNT;
          end
        end
        gfc_pkg::GFC_PH_COUNT: begin
          if (!read_w) begin
            phase_q <= gfc_pkg::GFC_PH_SHOW;
          end
        end
        gfc_pkg::GFC_PH_SHOW: begin
          if (trig_q) begin
            phase_q <= gfc_pkg::GFC_PH_RESET;
          end else if (read_w) begin
            phase_q <= gfc_pkg::GFC_PH_COUNT;
          end
        end
        default: begin
          phase_q <= gfc_pkg::GFC_PH_SHOW;
        end
      endcase
    end
  end

  assign phase = phase_q;

endmodule : gfc_counter

/* File: sim/gfc_counter_asserts.sv */
`include "gfc_defs.svh"

module gfc_counter_asserts #(
  parameter int DIGITS  = 4,
  parameter int REF_DIV = 10,
  parameter int RST_CYC = 4
) (
  input wire logic                            clk,
  input wire logic                            nrst,
  input wire logic                            rf_in,
  input wire logic                            ref_tick,
  input wire logic                            read_cmd,
  input wire logic                            count_gate,
  input wire logic                            trigger,
  input wire logic                            reset_pulse,
  input wire logic                            display_on,
  input wire logic [DIGITS*`GFC_NUMERALS-1:0] digit_drive,
  input wire logic [DIGITS*`GFC_BCD_W-1:0]    count_bcd,
  input wire logic                            overrange,
  input wire gfc_pkg::gfc_phase_t             phase
);
  localparam int RC1 = RST_CYC + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  int unsigned tick_gap_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_gap_q <= 0;
    end else if (ref_tick) begin
      tick_gap_q <= 1;
    end else begin
      tick_gap_q <= tick_gap_q + 1;
    end
  end
  property p_tick; ref_tick == (tick_gap_q == REF_DIV); endproperty
  a_tick: assert property (p_tick) else $error("tick spacing");
  property p_pass; read_cmd |=> count_gate == !$past(rf_in); endproperty
  a_pass: assert property (p_pass) else $error("gate pass");
  property p_shut; !read_cmd |=> count_gate; endproperty
  a_shut: assert property (p_shut) else $error("gate shut");
  property p_blank; read_cmd |=> !display_on && digit_drive == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("not blank");
  property p_show; !read_cmd |=> display_on; endproperty
  a_show: assert property (p_show) else $error("not lit");
  property p_hold;
    !read_cmd && !$past(read_cmd, 3) && !reset_pulse
      && !$past(reset_pulse, 3) |=> $stable(count_bcd);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_trig; trigger |=> !trigger && reset_pulse; endproperty
  a_trig: assert property (p_trig) else $error("trigger");
  property p_width;
    $fell(reset_pulse) |-> $past(reset_pulse, RST_CYC)
      && !$past(reset_pulse, RC1);
  endproperty
  a_width: assert property (p_width) else $error("reset width");
  property p_clr; $fell(reset_pulse) |-> count_bcd == '0; endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  property p_order; $rose(read_cmd) |-> !reset_pulse && !$past(reset_pulse);
  endproperty
  a_order: assert property (p_order) else $error("reset late");
  property p_cond; $rose(trigger) |-> !read_cmd; endproperty
  a_cond: assert property (p_cond) else $error("trigger phase");
  c_trig: cover property (trigger);
  c_fell: cover property ($fell(read_cmd));
  c_rose: cover property ($rose(read_cmd));
endmodule : gfc_counter_asserts

bind gfc_counter gfc_counter_asserts #(
  .DIGITS(DIGITS), .REF_DIV(REF_DIV), .RST_CYC(RST_CYC)
) u_chk (
  .clk(clk), .nrst(nrst), .rf_in(rf_in), .ref_tick(ref_tick),
  .read_cmd(read_cmd), .count_gate(count_gate), .trigger(trigger),
  .reset_pulse(reset_pulse), .display_on(display_on),
  .digit_drive(digit_drive), .count_bcd(count_bcd),
  .overrange(overrange), .phase(phase)
);

/* File: sim/gfc_rf_src.sv */
module gfc_rf_src (
  input wire logic       clk,
  input wire logic [7:0] half,
  output     logic       rf_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q;
  initial begin
    rf_in = 1'h0;
    cnt_q = 8'h00;
  end
  // Square wave, half period in clocks
  always @(negedge clk) begin
    if (cnt_q + 8'h01 >= half) begin
      rf_in <= ~rf_in;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : gfc_rf_src

/* File: sim/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                clk;
  logic                nrst;
  logic                rf_in;
  logic [7:0]          half;
  logic                read_cmd;
  logic                count_gate;
  logic                trigger;
  logic                reset_pulse;
  logic                display_on;
  logic [39:0]         digit_drive;
  logic [15:0]         count_bcd;
  logic                overrange;
  gfc_pkg::gfc_phase_t phase;
  int                  err_count;
  int                  tests_run;

  gfc_counter #(.DIGITS(4), .REF_DIV(10), .RST_CYC(4)) uut (
    .clk(clk), .nrst(nrst), .rf_in(rf_in), .ref_tick(),
    .read_cmd(read_cmd), .count_gate(count_gate), .trigger(trigger),
    .reset_pulse(reset_pulse), .display_on(display_on),
    .digit_drive(digit_drive), .count_bcd(count_bcd),
    .overrange(overrange), .phase(phase)
  );
  gfc_rf_src rf (.clk(clk), .half(half), .rf_in(rf_in));

  always #2.5 clk = ~clk;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic t_reset_state;
    check(read_cmd, 1'h1);
    check(display_on, 1'h0);
    check(digit_drive, '0);
  endtask : t_reset_state

  task automatic t_measure(input int exp, input logic [7:0] nh);
    int          n;
    int          v;
    time         t0;
    logic [39:0] dd;
    logic [15:0] bcd;
    for (n = 0; n < 30000 && read_cmd !== 1'h0; n++) @(negedge clk);
    t0 = $time;
    repeat (5) @(negedge clk);
    bcd = count_bcd;
    v = 0;
    dd = '0;
    for (int g = 3; g >= 0; g--) begin
      v = v * 10 + int'(bcd[g*4+:4]);
      dd[g*10+:10] = 10'h001 << bcd[g*4+:4];
    end
    check(v >= exp - 2 && v <= exp + 2, 1'h1);
    check(display_on, 1'h1);
    check(digit_drive, dd);
    check(overrange, 1'h0);
    check($isunknown(bcd), 1'h0);
    check(phase, gfc_pkg::GFC_PH_SHOW);
    repeat (2000) @(negedge clk);
    check(count_bcd, bcd);
    check(count_gate, 1'h1);
    half = nh;
    for (n = 0; n < 12000 && trigger !== 1'h1; n++) @(negedge clk);
    check(read_cmd, 1'h0);
    check(trigger, 1'h1);
    @(negedge clk);
    check(reset_pulse, 1'h1);
    check(phase, gfc_pkg::GFC_PH_RESET);
    repeat (6) @(negedge clk);
    check(count_bcd, 16'h0000);
    for (n = 0; n < 12000 && read_cmd !== 1'h1; n++) @(negedge clk);
    check(64'($time - t0), 64'hC350);
    check(reset_pulse, 1'h0);
    @(negedge clk);
    check(digit_drive, '0);
    check(phase, gfc_pkg::GFC_PH_COUNT);
  endtask : t_measure

  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    half = 8'h05;
    err_count = 0;
    tests_run = 0;
    repeat (5) @(negedge clk);
    nrst = 1'h1;
    @(negedge clk);
    t_reset_state;
    t_measure(1000, 8'h0A);
    t_measure(500, 8'h0A);
    report_and_stop;
  end

  initial begin
    #400000;
    err_count++;
    report_and_stop;
  end
endmodule : tb_top
